// [rtl/pwc_pkg.sv]
// Constants shared by the power state and wake control block
package pwc_pkg;
  // Register byte addresses
  localparam logic [7:0] PMC_OFFSET = 8'h84;
  localparam logic [7:0] TEST_OFFSET = 8'hf0;
  // Read value of the endian test register; arbitrary pattern
  localparam logic [31:0] TEST_PATTERN = 32'h8765_4321;

  // Field positions inside power_management_control
  localparam int MODE_LSB = 13 - 1;
  localparam int TRST_BIT = 10;
  localparam int WOL_BIT = 9;
  localparam int ED_BIT = 8;
  localparam int TYPE_BIT = 6;
  localparam int WAKE_CAUSE_STATUS_LSB = 4;
  localparam int IND_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int EN_BIT = 1;
  localparam int READY_BIT = 0;

  // Power state encodings
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_FRAME_WAKE = 2'h1;
  localparam logic [1:0] MODE_ENERGY = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // Wake cause bits
  localparam int WAKE_CAUSE_STATUS_ED = 0;
  localparam int WAKE_CAUSE_STATUS_WOL = 1;

  // Reset values of the writable fields
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [1:0] RST_WAKE_CAUSE_STATUS = 2'h0;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int TRST_US = 100;
  localparam int PULSE_MS = 50;
  localparam int TRST_CYC = TRST_US * CLK_MHZ;
  localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYC = 16;
  localparam int TIMER_W = 24;
endpackage

// [rtl/pwc_timer.sv]
// One-shot countdown timer with busy level and done pulse
module pwc_timer #(
  parameter int unsigned LOAD = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [pwc_pkg::TIMER_W-1:0] count_ff;
  logic [pwc_pkg::TIMER_W-1:0] nxt_count;

  always_comb
  begin
    nxt_count = count_ff;
    if (start_i)
      nxt_count = pwc_pkg::TIMER_W'(LOAD);
    else if (count_ff != '0)
      nxt_count = count_ff - pwc_pkg::TIMER_W'(1);
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

  assign busy_o = (count_ff != '0);
  assign done_o = (count_ff == pwc_pkg::TIMER_W'(1)) && !start_i;

  a_timer_load: assert property (@(posedge clock_i) disable iff (rst_i)
    start_i |=> count_ff == pwc_pkg::TIMER_W'(LOAD))
    else $error("timer did not load its count");
endmodule

// [rtl/pwc_wake_out.sv]
// Wake output pin driver: open-drain or push-pull with polarity
module pwc_wake_out (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic active_i,
  input wire logic push_pull_i,
  input wire logic active_high_i,
  output logic pin_o,
  output logic pin_oe_o
);
  logic pin_ff;
  logic oe_ff;
  logic nxt_pin;
  logic nxt_oe;

  always_comb
  begin
    if (push_pull_i)
    begin
      nxt_oe = 1'b1;
      nxt_pin = active_high_i ? active_i : !active_i;
    end
    else
    begin
      // Open drain only ever pulls low, polarity is meaningless here
      nxt_oe = active_i;
      nxt_pin = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pin_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      pin_ff <= nxt_pin;
      oe_ff <= nxt_oe;
    end
  end

  assign pin_o = pin_ff;
  assign pin_oe_o = oe_ff;

  a_open_drain_low: assert property (@(posedge clock_i) disable iff (rst_i)
    !push_pull_i |=> !pin_o && (pin_oe_o == $past(active_i)))
    else $error("open-drain wake output not active low");

  a_push_pull_pol: assert property (@(posedge clock_i) disable iff (rst_i)
    push_pull_i |=> pin_oe_o && (pin_o == ($past(active_i) == $past(active_high_i))))
    else $error("push-pull wake output level wrong");
endmodule

// [rtl/pwc_power_ctl.sv]
// Power state, transceiver reset and wake event control register block
// Overview of operation
// - Bits 13:12 select normal, frame-wake, energy state
// - Power state resets normal, clears itself on wake
// - Endian test register write wakes reduced-power device
// - Control register stays readable in every power state
// - Writes ignored until first read after reset/wake
// - Bit 10 write holds transceiver reset 100us
// - Reset bit self-clears; writes to it ignored while set, other fields still written
// - Wake-on-LAN event drives wake output and interrupt
// - Energy event drives wake output and interrupt
// - Bit 6 chooses open-drain or push-pull, reset 0
// - Open-drain wake output ignores polarity, active low
// - Pulse select gives 50ms pulse, else level
// - Output enable gates only pin, not interrupt
// - Two-bit wake cause, write one clears
// - Ready bit set only after stabilizing
module pwc_power_ctl #(
  parameter int unsigned TRST_CYCLES = pwc_pkg::TRST_CYC,
  parameter int unsigned PULSE_CYCLES = pwc_pkg::PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  output logic [31:0] bus_rdata_o,
  output logic bus_rvalid_o,
  input wire logic wol_event_i,
  input wire logic energy_event_i,
  output logic [1:0] power_state_select_o,
  output logic transceiver_reset_o,
  output logic wake_interrupt_o,
  output logic wake_event_output_o,
  output logic wake_event_output_oe_o
);
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic trst_ff;
  logic nxt_trst;
  logic wake_on_lan_enable_ff;
  logic nxt_wake_on_lan_enable;
  logic energy_detect_enable_ff;
  logic nxt_energy_detect_enable;
  logic type_ff;
  logic nxt_type;
  logic pol_ff;
  logic nxt_pol;
  logic ind_ff;
  logic nxt_ind;
  logic wake_output_enable_ff;
  logic nxt_wake_output_enable;
  logic read_seen_ff;
  logic nxt_read_seen;
  logic boot_ff;
  logic ready_ff;
  logic nxt_ready;
  logic [1:0] wake_cause_status_ff;
  logic [1:0] nxt_wake_cause_status;
  logic [1:0] wake_cause_status_set;
  logic int_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rvalid_ff;

  logic pmc_hit;
  logic test_hit;
  logic reduced;
  logic wake_write;
  logic pmc_write;
  logic trst_start;
  logic trst_done;
  logic settle_busy;
  logic pulse_busy;
  logic out_active;
  logic [31:0] pmc_value;

  assign pmc_hit = (bus_addr_i == pwc_pkg::PMC_OFFSET);
  assign test_hit = (bus_addr_i == pwc_pkg::TEST_OFFSET);
  assign reduced = (mode_ff != pwc_pkg::MODE_NORMAL);
  // Wake write is honoured even before the first read, else no way back
  assign wake_write = bus_wr_i && test_hit && reduced;
  // Other writes need a read first and a ready device
  assign pmc_write = bus_wr_i && pmc_hit && read_seen_ff && ready_ff;
  assign trst_start = pmc_write && bus_wdata_i[pwc_pkg::TRST_BIT] && !trst_ff;

  // Transceiver reset hold time, self-timed
  pwc_timer #(
    .LOAD(TRST_CYCLES)
  ) u_trst_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(trst_start),
    .busy_o(),
    .done_o(trst_done)
  );

  // Settling after reset or wake before ready is shown
  pwc_timer #(
    .LOAD(pwc_pkg::SETTLE_CYC)
  ) u_settle_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(boot_ff || wake_write),
    .busy_o(settle_busy),
    .done_o()
  );

  // Wake output pulse length
  pwc_timer #(
    .LOAD(PULSE_CYCLES)
  ) u_pulse_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .start_i(wake_cause_status_set != 2'h0),
    .busy_o(pulse_busy),
    .done_o()
  );

  // Control fields
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_trst = trst_ff;
    nxt_wake_on_lan_enable = wake_on_lan_enable_ff;
    nxt_energy_detect_enable = energy_detect_enable_ff;
    nxt_type = type_ff;
    nxt_pol = pol_ff;
    nxt_ind = ind_ff;
    nxt_wake_output_enable = wake_output_enable_ff;
    if (pmc_write)
    begin
      // Reserved code is not taken; the field keeps normal state
      if (bus_wdata_i[pwc_pkg::MODE_LSB+:2] != pwc_pkg::MODE_RESERVED)
        nxt_mode = bus_wdata_i[pwc_pkg::MODE_LSB+:2];
      nxt_wake_on_lan_enable = bus_wdata_i[pwc_pkg::WOL_BIT];
      nxt_energy_detect_enable = bus_wdata_i[pwc_pkg::ED_BIT];
      nxt_type = bus_wdata_i[pwc_pkg::TYPE_BIT];
      nxt_pol = bus_wdata_i[pwc_pkg::POL_BIT];
      nxt_ind = bus_wdata_i[pwc_pkg::IND_BIT];
      nxt_wake_output_enable = bus_wdata_i[pwc_pkg::EN_BIT];
    end
    if (wake_write)
      nxt_mode = pwc_pkg::MODE_NORMAL;
    if (trst_start)
      nxt_trst = 1'b1;
    else if (trst_done)
      nxt_trst = 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mode_ff <= pwc_pkg::MODE_NORMAL;
      trst_ff <= 1'b0;
      wake_on_lan_enable_ff <= pwc_pkg::RST_ENABLE;
      energy_detect_enable_ff <= pwc_pkg::RST_ENABLE;
      type_ff <= pwc_pkg::RST_ENABLE;
      pol_ff <= pwc_pkg::RST_ENABLE;
      ind_ff <= pwc_pkg::RST_ENABLE;
      wake_output_enable_ff <= pwc_pkg::RST_ENABLE;
    end
    else
    begin
      mode_ff <= nxt_mode;
      trst_ff <= nxt_trst;
      wake_on_lan_enable_ff <= nxt_wake_on_lan_enable;
      energy_detect_enable_ff <= nxt_energy_detect_enable;
      type_ff <= nxt_type;
      pol_ff <= nxt_pol;
      ind_ff <= nxt_ind;
      wake_output_enable_ff <= nxt_wake_output_enable;
    end
  end

  // Access gating: read-first latch and ready
  always_comb
  begin
    nxt_read_seen = read_seen_ff;
    if (bus_rd_i)
      nxt_read_seen = 1'b1;
    if (wake_write)
      nxt_read_seen = 1'b0;
    nxt_ready = !nxt_read_seen ? ready_ff : ready_ff;
    nxt_ready = (nxt_mode == pwc_pkg::MODE_NORMAL) && !settle_busy && !boot_ff
      && !wake_write;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      read_seen_ff <= 1'b0;
      boot_ff <= 1'b1;
      ready_ff <= 1'b0;
    end
    else
    begin
      read_seen_ff <= nxt_read_seen;
      boot_ff <= 1'b0;
      ready_ff <= nxt_ready;
    end
  end

  // Wake cause bits; a new event wins over a clear in the same cycle
  assign wake_cause_status_set[pwc_pkg::WAKE_CAUSE_STATUS_ED] = energy_event_i && energy_detect_enable_ff;
  assign wake_cause_status_set[pwc_pkg::WAKE_CAUSE_STATUS_WOL] = wol_event_i && wake_on_lan_enable_ff;

  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_wake_cause_status
      always_comb
      begin
        nxt_wake_cause_status[i] = wake_cause_status_ff[i];
        if (pmc_write && bus_wdata_i[pwc_pkg::WAKE_CAUSE_STATUS_LSB + i])
          nxt_wake_cause_status[i] = 1'b0;
        if (wake_cause_status_set[i])
          nxt_wake_cause_status[i] = 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wake_cause_status_ff <= pwc_pkg::RST_WAKE_CAUSE_STATUS;
      int_ff <= 1'b0;
    end
    else
    begin
      wake_cause_status_ff <= nxt_wake_cause_status;
      int_ff <= (nxt_wake_cause_status != 2'h0);
    end
  end

  // Pin activity: enable gates only the pin
  assign out_active = wake_output_enable_ff && (ind_ff ? pulse_busy : (wake_cause_status_ff != 2'h0));

  pwc_wake_out u_wake_out (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .active_i(out_active),
    .push_pull_i(type_ff),
    .active_high_i(pol_ff),
    .pin_o(wake_event_output_o),
    .pin_oe_o(wake_event_output_oe_o)
  );

  // Read path; reserved positions stay zero
  always_comb
  begin
    pmc_value = 32'h0000_0000;
    pmc_value[pwc_pkg::MODE_LSB+:2] = mode_ff;
    pmc_value[pwc_pkg::TRST_BIT] = trst_ff;
    pmc_value[pwc_pkg::WOL_BIT] = wake_on_lan_enable_ff;
    pmc_value[pwc_pkg::ED_BIT] = energy_detect_enable_ff;
    pmc_value[pwc_pkg::TYPE_BIT] = type_ff;
    pmc_value[pwc_pkg::WAKE_CAUSE_STATUS_LSB+:2] = wake_cause_status_ff;
    pmc_value[pwc_pkg::IND_BIT] = ind_ff;
    pmc_value[pwc_pkg::POL_BIT] = pol_ff;
    pmc_value[pwc_pkg::EN_BIT] = wake_output_enable_ff;
    pmc_value[pwc_pkg::READY_BIT] = ready_ff;
    nxt_rdata = 32'h0000_0000;
    if (bus_rd_i && pmc_hit)
      nxt_rdata = pmc_value;
    else if (bus_rd_i && test_hit)
      nxt_rdata = pwc_pkg::TEST_PATTERN;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= 32'h0000_0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= bus_rd_i;
    end
  end

  assign bus_rdata_o = rdata_ff;
  assign bus_rvalid_o = rvalid_ff;
  assign power_state_select_o = mode_ff;
  assign transceiver_reset_o = trst_ff;
  assign wake_interrupt_o = int_ff;

  // Checking helpers
  logic [pwc_pkg::TIMER_W-1:0] hold_cnt_ff;
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !trst_ff)
      hold_cnt_ff <= '0;
    else
      hold_cnt_ff <= hold_cnt_ff + pwc_pkg::TIMER_W'(1);
  end

  sequence s_wake_write;
    bus_wr_i && test_hit && (mode_ff != pwc_pkg::MODE_NORMAL);
  endsequence

  sequence s_back_normal;
    (mode_ff == pwc_pkg::MODE_NORMAL) && !ready_ff && !read_seen_ff;
  endsequence

  a_wake_returns: assert property (@(posedge clock_i) disable iff (rst_i)
    s_wake_write |=> s_back_normal)
    else $error("wake write did not return to normal state");

  a_mode_decode: assert property (@(posedge clock_i) disable iff (rst_i)
    pmc_write && !wake_write && bus_wdata_i[13:12] != pwc_pkg::MODE_RESERVED
    |=> power_state_select_o == $past(bus_wdata_i[13:12]))
    else $error("power state field not taken");

  a_read_first: assert property (@(posedge clock_i) disable iff (rst_i)
    bus_wr_i && pmc_hit && !read_seen_ff |=> $stable(wake_on_lan_enable_ff) && $stable(wake_output_enable_ff)
      && $stable(type_ff))
    else $error("write accepted before first read");

  a_trst_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(trst_ff) |-> $past(hold_cnt_ff) >= pwc_pkg::TIMER_W'(TRST_CYCLES - 1))
    else $error("transceiver reset released early");

  a_trst_ignore: assert property (@(posedge clock_i) disable iff (rst_i)
    trst_ff && !trst_done |=> trst_ff)
    else $error("transceiver reset bit dropped early");

  a_wol_cause: assert property (@(posedge clock_i) disable iff (rst_i)
    wol_event_i && wake_on_lan_enable_ff |=> wake_cause_status_ff[pwc_pkg::WAKE_CAUSE_STATUS_WOL] ##1 wake_interrupt_o)
    else $error("wake-on-LAN event not recorded");

  a_ed_cause: assert property (@(posedge clock_i) disable iff (rst_i)
    energy_event_i && energy_detect_enable_ff |=> wake_cause_status_ff[pwc_pkg::WAKE_CAUSE_STATUS_ED] ##1 wake_interrupt_o)
    else $error("energy event not recorded");

  a_pulse_len: assert property (@(posedge clock_i) disable iff (rst_i)
    (wake_cause_status_set != 2'h0) |=> pulse_busy [*8])
    else $error("wake pulse shorter than expected");

  a_ready_settle: assert property (@(posedge clock_i) disable iff (rst_i)
    s_wake_write |=> !ready_ff [*8])
    else $error("ready shown before settling");

  a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    bus_rd_i && pmc_hit |=> bus_rdata_o[31:14] == 18'h0_0000 && !bus_rdata_o[11]
      && !bus_rdata_o[7])
    else $error("reserved bits read nonzero");
endmodule

// [verif/pwc_host.sv]
// Host processor model for the power control register strobes
module pwc_host (
  input wire logic clock_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic rd_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 32'h0000_0000;
  end

  // One idle cycle first, so a strobe is never set twice in a step
  // Released lines show the inverse, never a stale copy
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clock_i);
    #1;
    d = rvalid_i ? rdata_i : 32'hxxxx_xxxx;
    rd_o = 1'b0;
    addr_o = ~a;
  endtask

  // Never writes the reserved power state encoding
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // Polls ready by reads only; no other write before it is set
  task automatic wait_ready(output logic ok);
    logic [31:0] d;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      rd_reg(pwc_pkg::PMC_OFFSET, d);
      ok = (d[pwc_pkg::READY_BIT] === 1'b1);
    end
  endtask
endmodule

// [verif/pwc_power_ctl_tb.sv]
// Self-checking testbench of the power state and wake control block
module pwc_power_ctl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Shortened counts keep the run small
  localparam int TRST = 40;
  localparam int PULSE = 20;
  localparam logic [7:0] PMC = pwc_pkg::PMC_OFFSET;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic bus_rd_i;
  logic bus_wr_i;
  logic [7:0] bus_addr_i;
  logic [31:0] bus_wdata_i;
  logic [31:0] bus_rdata_o;
  logic bus_rvalid_o;
  logic wol_event_i = 1'b0;
  logic energy_event_i = 1'b0;
  logic [1:0] power_state_select_o;
  logic transceiver_reset_o;
  logic wake_interrupt_o;
  logic wake_event_output_o;
  logic wake_event_output_oe_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cnt;
  logic [31:0] rd;
  logic ok;

  always #2.5 clock_i = ~clock_i;

  pwc_host u_host (
    .clock_i(clock_i),
    .rdata_i(bus_rdata_o),
    .rvalid_i(bus_rvalid_o),
    .rd_o(bus_rd_i),
    .wr_o(bus_wr_i),
    .addr_o(bus_addr_i),
    .wdata_o(bus_wdata_i)
  );

  pwc_power_ctl #(.TRST_CYCLES(TRST), .PULSE_CYCLES(PULSE)) u_dut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .bus_rd_i(bus_rd_i),
    .bus_wr_i(bus_wr_i),
    .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o),
    .bus_rvalid_o(bus_rvalid_o),
    .wol_event_i(wol_event_i),
    .energy_event_i(energy_event_i),
    .power_state_select_o(power_state_select_o),
    .transceiver_reset_o(transceiver_reset_o),
    .wake_interrupt_o(wake_interrupt_o),
    .wake_event_output_o(wake_event_output_o),
    .wake_event_output_oe_o(wake_event_output_oe_o)
  );

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    u_host.rd_reg(a, rd);
    chk_word(rd, exp, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // One-cycle event pulse; the far side counts every high cycle
  task automatic evt(input logic wol);
    cyc(1);
    wol_event_i = wol;
    energy_event_i = !wol;
    cyc(1);
    wol_event_i = 1'b0;
    energy_event_i = 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    chk_word({30'h0, power_state_select_o}, 32'h0000_0000, "state at reset");
    chk_bit(wake_event_output_oe_o, 1'b0, "pin idle at reset");
    cyc(20);
    u_host.wr_reg(PMC, 32'h0000_0300);
    rdchk(PMC, 32'h0000_0001, "write before read");
    u_host.wr_reg(PMC, 32'hffff_c980);
    rdchk(PMC, 32'h0000_0101, "reserved bits");
    rdchk(8'h88, 32'h0000_0000, "unmapped read");
    rdchk(pwc_pkg::TEST_OFFSET, pwc_pkg::TEST_PATTERN, "test register");
    // Second write lands while set; a restart would lengthen the pulse
    u_host.wr_reg(PMC, 32'h0000_0400);
    u_host.wr_reg(PMC, 32'h0000_0400);
    cnt = 0;
    repeat (TRST + 20)
    begin
      cnt += int'(transceiver_reset_o === 1'b1);
      cyc(1);
    end
    chk_word(32'(cnt), 32'(TRST - 2), "reset length");
    rdchk(PMC, 32'h0000_0001, "reset bit cleared");
    u_host.wr_reg(PMC, 32'h0000_0306);
    evt(1'b1);
    cyc(2);
    chk_bit(wake_interrupt_o, 1'b1, "wol interrupt");
    chk_bit(wake_event_output_oe_o, 1'b1, "open drain oe");
    chk_bit(wake_event_output_o, 1'b0, "open drain low");
    rdchk(PMC, 32'h0000_0327, "cause wol");
    evt(1'b0);
    rdchk(PMC, 32'h0000_0337, "cause both");
    u_host.wr_reg(PMC, 32'h0000_0332);
    cyc(2);
    chk_bit(wake_interrupt_o, 1'b0, "cause cleared");
    chk_bit(wake_event_output_oe_o, 1'b0, "pin released");
    u_host.wr_reg(PMC, 32'h0000_0300);
    evt(1'b0);
    cyc(2);
    chk_bit(wake_interrupt_o, 1'b1, "energy interrupt");
    chk_bit(wake_event_output_oe_o, 1'b0, "pin gated");
    // Clear the cause too, and let the earlier pulse run out before idle is judged
    u_host.wr_reg(PMC, 32'h0000_037e);
    cyc(PULSE);
    chk_bit(wake_interrupt_o, 1'b0, "cleared by write");
    chk_bit(wake_event_output_oe_o, 1'b1, "push pull oe");
    chk_bit(wake_event_output_o, 1'b0, "high idle");
    evt(1'b1);
    cnt = 0;
    repeat (2 * PULSE)
    begin
      cnt += int'(wake_event_output_o === 1'b1);
      cyc(1);
    end
    chk_word(32'(cnt), 32'(PULSE), "pulse length");
    u_host.wr_reg(PMC, 32'h0000_0372);
    cyc(2);
    chk_bit(wake_event_output_o, 1'b1, "low idle");
    evt(1'b0);
    cyc(30);
    chk_bit(wake_event_output_o, 1'b0, "level held");
    u_host.wr_reg(PMC, 32'h0000_0372);
    cyc(3);
    chk_bit(wake_event_output_o, 1'b1, "level released");
    for (int m = 1; m < 3; m++)
    begin
      u_host.wr_reg(PMC, 32'(m) << 12);
      cyc(1);
      chk_word({30'h0, power_state_select_o}, 32'(m), "state select");
      // Ready stays clear in a reduced state
      rdchk(PMC, 32'(m) << 12, "readable asleep");
      u_host.wr_reg(pwc_pkg::TEST_OFFSET, 32'h0000_0000);
      chk_word({30'h0, power_state_select_o}, 32'h0000_0000, "woken");
      rdchk(PMC, 32'h0000_0000, "not ready");
      u_host.wait_ready(ok);
      chk_bit(ok, 1'b1, "ready again");
    end
    test_done();
  end

  // Tests take a few hundred cycles; this is a wide margin
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    $display("mismatch t=%0t watchdog expired", $time);
    test_done();
  end
endmodule
